// File: lcc_pkg.sv
// constants, types and register map of the line channel A control block
// ------------------------------------------------------------------------
// What this block does
// - writing 1 to establish_link_start begins wake-up and rate detection
// - on success raise wake-up done event and clear establish_link_start
// - raise current limit boost during sequence wake pulse only, settings untouched
// - on success store detected rate and readable device cycle time
// - on failure raise wake-up done event, bit at 0, rate field 00
// - writing 1 to manual_wakeup_pulse drives a wake-up request at once
// - after the manual wake-up request the line goes to receive mode
// - manual_wakeup_pulse clears itself once the request has finished
// - writing transmit_queue_clear empties the transmit queue
// - writing receive_queue_clear empties the receive queue
// - cycle_timer_arm only arms the cycle timer, never starts it
// - armed timer starts on master_message_send write or trigger command
// - clearing cycle_timer_arm stops the timer at once, mid cycle too
// - master_message_send puts line in transmit mode and sends the queue
// - message sent and queue empty turns the line to receive mode
// - send also starts an enabled timer; the send bit clears itself
// - rate field: 00 failure, 01 4.8k, 10 38.4k, 11 230.4k
// ------------------------------------------------------------------------
package lcc_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] LCC_IDX_CTRL = 6'h06;
    localparam logic [5:0] LCC_IDX_CFG = 6'h08;
    localparam logic [5:0] LCC_IDX_TXDATA = 6'h09;
    localparam logic [5:0] LCC_IDX_RXDATA = 6'h0A;
    localparam logic [5:0] LCC_IDX_STATUS = 6'h0B;
    localparam logic [5:0] LCC_IDX_CYCTIME = 6'h0C;
    // control and config register fields
    localparam int LCC_CTRL_SEND = 0;
    localparam int LCC_CTRL_ARM = 1;
    localparam int LCC_CTRL_RXCLR = 2;
    localparam int LCC_CTRL_TXCLR = 3;
    localparam int LCC_CTRL_WAKE = 4;
    localparam int LCC_CTRL_EST = 5;
    localparam int LCC_CTRL_RATE_LO = 6;
    localparam int LCC_CFG_FRAMER_EN = 0;
    // status register fields
    localparam int LCC_ST_WAKE_DONE = 0;
    localparam int LCC_ST_TX_EMPTY = 1;
    localparam int LCC_ST_RX_EMPTY = 2;
    localparam int LCC_ST_TMR_RUN = 3;
    localparam int LCC_ST_XMIT = 4;
    localparam int LCC_ST_BOOST = 5;
    localparam int LCC_ST_TX_FULL = 6;
    // rate field encodings
    localparam logic [1:0] LCC_RATE_FAIL = 2'h0;
    localparam logic [1:0] LCC_RATE_COM1 = 2'h1;
    localparam logic [1:0] LCC_RATE_COM2 = 2'h2;
    localparam logic [1:0] LCC_RATE_COM3 = 2'h3;
    // reset values
    localparam logic [1:0] LCC_RATE_RST = 2'h0;
    localparam logic [7:0] LCC_CYCTIME_RST = 8'h00;
    // timing
    localparam int LCC_CLK_PERIOD_NS = 10;
    localparam int LCC_WAKE_PULSE_NS = 80000;
    localparam int LCC_WAKE_PULSE_CYC = LCC_WAKE_PULSE_NS / LCC_CLK_PERIOD_NS;
    localparam int LCC_CYCLE_NS = 1000000;
    localparam int LCC_CYCLE_CYC = LCC_CYCLE_NS / LCC_CLK_PERIOD_NS;
    localparam int LCC_FIFO_DEPTH = 32;
    // establish and wake sequencer
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_PULSE = 2'b01,
        SEQ_PROBE = 2'b10,
        SEQ_WAIT = 2'b11
    } lcc_seq_type;
endpackage

// File: lcc_top.sv
// line channel A control: queues, sequencer, cycle timer and bus slave
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ns

// ------------------------------------------------------------------------
// synchronous fifo with clear
// ------------------------------------------------------------------------
module lcc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_r != DEPTH[AW:0]);
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem_r[rd_r];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // storage has no reset; only pointers define the contents
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_r] <= in_data_i;
        end
    end

    // pointers and level; clear drops everything, including a same-cycle push
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // lcc_fifo

// ------------------------------------------------------------------------
// top
// ------------------------------------------------------------------------
module lcc_top import lcc_pkg::*; #(
    parameter int WAKE_CYC = LCC_WAKE_PULSE_CYC,
    parameter int CYCLE_CYC = LCC_CYCLE_CYC,
    parameter int DEPTH = LCC_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // channel_a_line pin
    input wire logic line_i,
    output logic line_o,
    output logic line_oe_o,
    output logic boost_o,
    // framer side, same clock
    input wire logic framer_bit_i,
    input wire logic framer_idle_i,
    output logic line_rx_o,
    output logic [7:0] tx_byte_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    output logic probe_start_o,
    output logic [1:0] probe_rate_o,
    input wire logic probe_done_i,
    input wire logic probe_ok_i,
    input wire logic [7:0] probe_cycle_i,
    input wire logic trigger_i,
    output logic cycle_tick_o,
    output logic wakeup_done_irq_o
);
    lcc_seq_type seq_r;
    logic [15:0] pulse_cnt_r;
    logic [23:0] tmr_cnt_r;
    logic [1:0] rate_r;
    logic [1:0] try_r;
    logic [7:0] cyc_time_r;
    logic [31:0] dat_r;
    logic ack_r, est_busy_r, wake_busy_r, arm_r, run_r, xmit_r, framer_en_r;
    logic wake_flag_r, irq_r, lvl_r, line_s1_r, line_s2_r;
    logic req, wr, rd, sel0, tx_full_stall;
    logic est_go, wake_go, send_go, txclr, rxclr, done_ok, done_fail;
    logic tx_in_ready, tx_out_valid, rx_out_valid;
    logic [7:0] rx_out_data;
    logic [5:0] idx;

    // ------------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------------
    assign idx = wb_adr_i[7:2];
    assign sel0 = wb_sel_i[0];
    // a push into a full transmit queue holds off ack until room appears
    assign tx_full_stall = wb_we_i & (idx == LCC_IDX_TXDATA) & ~tx_in_ready;
    assign req = wb_cyc_i & wb_stb_i & ~ack_r & ~tx_full_stall;
    assign wr = wb_cyc_i & wb_stb_i & ack_r & wb_we_i & sel0;
    assign rd = wb_cyc_i & wb_stb_i & ack_r & ~wb_we_i;
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // one cycle answer; writes act on the edge that the master sees ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    // read data latched with ack; unmapped words read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= '0;
        end else if (req && !wb_we_i) begin
            unique case (idx)
                LCC_IDX_CTRL: dat_r <= {24'h000000, rate_r, est_busy_r, wake_busy_r,
                                        2'b00, arm_r, 1'b0};
                LCC_IDX_CFG: dat_r <= {31'h00000000, framer_en_r};
                LCC_IDX_RXDATA: dat_r <= {24'h000000, rx_out_data};
                LCC_IDX_STATUS: dat_r <= {25'h0000000, ~tx_in_ready, boost_o, xmit_r,
                                          run_r, ~rx_out_valid, ~tx_out_valid,
                                          wake_flag_r};
                LCC_IDX_CYCTIME: dat_r <= {24'h000000, cyc_time_r};
                default: dat_r <= '0;
            endcase
        end
    end

    // write strobes of the control register
    assign est_go = wr & (idx == LCC_IDX_CTRL) & wb_dat_i[LCC_CTRL_EST];
    assign wake_go = wr & (idx == LCC_IDX_CTRL) & wb_dat_i[LCC_CTRL_WAKE];
    assign send_go = wr & (idx == LCC_IDX_CTRL) & wb_dat_i[LCC_CTRL_SEND];
    assign txclr = wr & (idx == LCC_IDX_CTRL) & wb_dat_i[LCC_CTRL_TXCLR];
    assign rxclr = wr & (idx == LCC_IDX_CTRL) & wb_dat_i[LCC_CTRL_RXCLR];

    // framer enable and cycle timer arm bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            framer_en_r <= 1'b0;
            arm_r <= 1'b0;
        end else begin
            if (wr && idx == LCC_IDX_CFG) begin
                framer_en_r <= wb_dat_i[LCC_CFG_FRAMER_EN];
            end
            if (wr && idx == LCC_IDX_CTRL) begin
                arm_r <= wb_dat_i[LCC_CTRL_ARM];
            end
        end
    end

    // ------------------------------------------------------------------------
    // line pin synchroniser
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_s1_r <= 1'b0;
            line_s2_r <= 1'b0;
        end else begin
            line_s1_r <= line_i;
            line_s2_r <= line_s1_r;
        end
    end
    assign line_rx_o = line_s2_r;

    // ------------------------------------------------------------------------
    // establish and wake-up sequencer
    // ------------------------------------------------------------------------
    assign done_ok = (seq_r == SEQ_WAIT) & probe_done_i & probe_ok_i;
    // without the framer the sequence cannot probe, so it fails at once
    assign done_fail = ((seq_r == SEQ_WAIT) & probe_done_i & ~probe_ok_i
                        & (try_r == LCC_RATE_COM1))
                       | ((seq_r == SEQ_IDLE) & est_go & ~framer_en_r);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_r <= SEQ_IDLE;
            pulse_cnt_r <= '0;
            try_r <= LCC_RATE_COM3;
            lvl_r <= 1'b0;
        end else begin
            unique case (seq_r)
                SEQ_IDLE: begin
                    if ((est_go && framer_en_r) || wake_go) begin
                        seq_r <= SEQ_PULSE;
                        pulse_cnt_r <= 16'(WAKE_CYC - 1);
                        lvl_r <= ~line_s2_r; // pulse drives the inverse level
                    end
                end
                SEQ_PULSE: begin
                    if (pulse_cnt_r != '0) begin
                        pulse_cnt_r <= pulse_cnt_r - 1'b1;
                    end else if (est_busy_r) begin
                        seq_r <= SEQ_PROBE;
                        try_r <= LCC_RATE_COM3;
                    end else begin
                        seq_r <= SEQ_IDLE;
                    end
                end
                SEQ_PROBE: seq_r <= SEQ_WAIT;
                SEQ_WAIT: begin
                    if (probe_done_i) begin
                        if (probe_ok_i || try_r == LCC_RATE_COM1) begin
                            seq_r <= SEQ_IDLE;
                        end else begin
                            try_r <= try_r - 1'b1; // fastest rate is tried first
                            seq_r <= SEQ_PROBE;
                        end
                    end
                end
            endcase
        end
    end

    // busy bits read back as the establish and wake control bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            est_busy_r <= 1'b0;
            wake_busy_r <= 1'b0;
        end else begin
            if (done_ok || done_fail) begin
                est_busy_r <= 1'b0;
            end else if (seq_r == SEQ_IDLE && est_go) begin
                est_busy_r <= 1'b1;
            end
            if (seq_r == SEQ_PULSE && pulse_cnt_r == '0 && !est_busy_r) begin
                wake_busy_r <= 1'b0;
            end else if (seq_r == SEQ_IDLE && wake_go && !est_go) begin
                wake_busy_r <= 1'b1;
            end
        end
    end

    // rate field and detected cycle time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rate_r <= LCC_RATE_RST;
            cyc_time_r <= LCC_CYCTIME_RST;
        end else if (done_ok) begin
            rate_r <= try_r;
            cyc_time_r <= probe_cycle_i;
        end else if (done_fail) begin
            rate_r <= LCC_RATE_FAIL;
        end else if (wr && idx == LCC_IDX_CTRL) begin
            rate_r <= wb_dat_i[LCC_CTRL_RATE_LO +: 2];
        end
    end

    // sticky done flag, write one to clear; a new event beats the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_flag_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            irq_r <= done_ok | done_fail;
            if (done_ok || done_fail) begin
                wake_flag_r <= 1'b1;
            end else if (wr && idx == LCC_IDX_STATUS && wb_dat_i[LCC_ST_WAKE_DONE]) begin
                wake_flag_r <= 1'b0;
            end
        end
    end
    assign wakeup_done_irq_o = irq_r;
    assign probe_start_o = (seq_r == SEQ_PROBE);
    assign probe_rate_o = try_r;
    // current boost only for the pulse of an establish sequence
    assign boost_o = (seq_r == SEQ_PULSE) & est_busy_r;

    // ------------------------------------------------------------------------
    // transmit mode and line drive
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xmit_r <= 1'b0;
        end else if (xmit_r && !tx_out_valid && framer_idle_i) begin
            xmit_r <= 1'b0;
        end else if (send_go && seq_r == SEQ_IDLE && !est_go && !wake_go) begin
            xmit_r <= 1'b1;
        end
    end
    assign line_oe_o = xmit_r | (seq_r == SEQ_PULSE);
    assign line_o = (seq_r == SEQ_PULSE) ? lvl_r : framer_bit_i;
    assign tx_valid_o = xmit_r & tx_out_valid;

    // ------------------------------------------------------------------------
    // cycle timer
    // ------------------------------------------------------------------------
    // a send refused by a busy sequencer still starts the armed timer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_r <= 1'b0;
            tmr_cnt_r <= '0;
        end else if (!arm_r || (wr && idx == LCC_IDX_CTRL && !wb_dat_i[LCC_CTRL_ARM])) begin
            run_r <= 1'b0;
            tmr_cnt_r <= '0;
        end else if (!run_r && (send_go || trigger_i)) begin
            run_r <= 1'b1;
            tmr_cnt_r <= 24'(CYCLE_CYC - 1);
        end else if (run_r) begin
            tmr_cnt_r <= (tmr_cnt_r == '0) ? 24'(CYCLE_CYC - 1) : tmr_cnt_r - 1'b1;
        end
    end
    assign cycle_tick_o = run_r & (tmr_cnt_r == '0);

    // ------------------------------------------------------------------------
    // queues
    // ------------------------------------------------------------------------
    lcc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_txq (
        .clk_i(clk_i), .rst_i(rst_i), .clear_i(txclr),
        .in_valid_i(wr && idx == LCC_IDX_TXDATA), .in_ready_o(tx_in_ready),
        .in_data_i(wb_dat_i[7:0]), .out_valid_o(tx_out_valid),
        .out_ready_i(xmit_r & tx_ready_i), .out_data_o(tx_byte_o)
    );
    lcc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rxq (
        .clk_i(clk_i), .rst_i(rst_i), .clear_i(rxclr),
        .in_valid_i(rx_valid_i), .in_ready_o(rx_ready_o),
        .in_data_i(rx_byte_i), .out_valid_o(rx_out_valid),
        .out_ready_i(rd && idx == LCC_IDX_RXDATA), .out_data_o(rx_out_data)
    );

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    est_starts_a: assert property (est_go && framer_en_r && seq_r == SEQ_IDLE |=>
        seq_r == SEQ_PULSE && est_busy_r && line_oe_o) else $error("est did not start");
    done_clears_a: assert property ((done_ok || done_fail) |=>
        !est_busy_r && wakeup_done_irq_o && wake_flag_r) else $error("est completion wrong");
    boost_only_a: assert property (boost_o |-> seq_r == SEQ_PULSE && line_oe_o)
        else $error("boost outside pulse");
    rate_store_a: assert property (done_ok |=> rate_r == $past(try_r)
        && cyc_time_r == $past(probe_cycle_i)) else $error("rate not stored");
    fail_rate_a: assert property (done_fail |=> rate_r == LCC_RATE_FAIL)
        else $error("fail rate not zero");
    wake_drive_a: assert property (wake_go && !est_go && seq_r == SEQ_IDLE |=>
        line_oe_o && wake_busy_r) else $error("wake not driven");
    wake_end_a: assert property (seq_r == SEQ_PULSE && pulse_cnt_r == '0
        && !est_busy_r && !xmit_r |=> !line_oe_o && !wake_busy_r) else $error("wake end");
    txq_clear_a: assert property (txclr |=> !tx_out_valid)
        else $error("tx queue not emptied");
    rxq_clear_a: assert property (rxclr |=> !rx_out_valid)
        else $error("rx queue not emptied");
    arm_idle_a: assert property (!run_r && !send_go && !trigger_i |=> !run_r)
        else $error("timer self started");
    tmr_start_a: assert property (arm_r && !run_r && (send_go || trigger_i) && !(wr &&
        idx == LCC_IDX_CTRL && !wb_dat_i[LCC_CTRL_ARM]) |=> run_r)
        else $error("timer not started");
    tmr_stop_a: assert property (!arm_r |-> !run_r && !cycle_tick_o)
        else $error("timer runs unarmed");
    xmit_turn_a: assert property (xmit_r && !tx_out_valid && framer_idle_i |=>
        !xmit_r) else $error("no turnaround");

    est_ok_c: cover property (done_ok);
    est_fail_c: cover property (done_fail ##1 wake_flag_r);
    send_c: cover property (send_go ##1 xmit_r ##[1:40] !xmit_r);
    tick_c: cover property (cycle_tick_o);
endmodule // lcc_top

// File: lcc_dev_model.sv
// behavioural framer and field device on the far side of the line control block
`timescale 1ns/1ns
module lcc_dev_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] ok_rate_i,
    input wire logic stall_i,
    input wire logic probe_start_i,
    input wire logic [1:0] probe_rate_i,
    input wire logic tx_valid_i,
    output logic probe_done_o,
    output logic probe_ok_o,
    output logic [7:0] probe_cycle_o,
    output logic tx_ready_o,
    output logic idle_o,
    output logic bit_o
);
    logic [2:0] dly_r;
    // probe answer three cycles late; only the commanded rate is accepted
    always_ff @(posedge clk_i) begin
        dly_r <= rst_i ? 3'h0 : {dly_r[1:0], probe_start_i};
    end
    // framer idles one cycle after its queue runs dry
    always_ff @(posedge clk_i) begin
        idle_o <= rst_i | ~tx_valid_i;
    end
    // serial bit toggles so a stale level never passes for real data
    always_ff @(posedge clk_i) begin
        bit_o <= rst_i ? 1'b0 : ~bit_o;
    end
    assign probe_done_o = dly_r[2];
    assign probe_ok_o = dly_r[2] & (probe_rate_i == ok_rate_i);
    assign probe_cycle_o = dly_r[2] ? 8'h2A : 8'hD5; // garbage outside the answer cycle
    assign tx_ready_o = ~stall_i;
endmodule // lcc_dev_model

// File: lcc_top_tb_top.sv
// self-checking bench for the line channel control block
`timescale 1ns/1ns
module lcc_top_tb_top import lcc_pkg::*;;
    localparam int WAKE = 20;
    localparam int CYC = 50;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, trig = 1'b0, stall = 1'b0, rxv = 1'b0;
    logic [7:0] adr = 8'h00, wdat = 8'h00, rxb = 8'h00, q, txb, pcyc;
    logic [1:0] okr = 2'h0, prate;
    logic [31:0] rdat;
    logic ack, lo, loe, boost, fbit, fidle, lrx, txv, txr, rxr, pst, pdone, pok, tick, irq;
    wire logic lin = loe ? lo : 1'b0; // pulled low while nobody drives
    int fails = 0, checks_done = 0, cnt = 0;
    always #5 clk = ~clk;
    lcc_top #(.WAKE_CYC(WAKE), .CYCLE_CYC(CYC), .DEPTH(32)) lcc_top_inst (.clk_i(clk),
        .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i({24'h000000, wdat}), .wb_dat_o(rdat), .wb_ack_o(ack),
        .line_i(lin), .line_o(lo), .line_oe_o(loe), .boost_o(boost), .framer_bit_i(fbit),
        .framer_idle_i(fidle), .line_rx_o(lrx), .tx_byte_o(txb), .tx_valid_o(txv),
        .tx_ready_i(txr), .rx_byte_i(rxb), .rx_valid_i(rxv), .rx_ready_o(rxr),
        .probe_start_o(pst), .probe_rate_o(prate), .probe_done_i(pdone), .probe_ok_i(pok),
        .probe_cycle_i(pcyc), .trigger_i(trig), .cycle_tick_o(tick), .wakeup_done_irq_o(irq));
    lcc_dev_model lcc_dev_model_inst (.clk_i(clk), .rst_i(rst), .ok_rate_i(okr),
        .stall_i(stall), .probe_start_i(pst), .probe_rate_i(prate), .tx_valid_i(txv),
        .probe_done_o(pdone), .probe_ok_o(pok), .probe_cycle_o(pcyc), .tx_ready_o(txr),
        .idle_o(fidle), .bit_o(fbit));
    // ------------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    // every wait is bounded; running out ends the run
    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        cnt = 0;
        do begin
            @(posedge clk);
            cnt++;
        end while (s !== v && cnt < lim);
        if (s !== v) begin
            chk("wait bound", 8'h00, 8'h01);
            tally_and_finish();
        end
    endtask
    // classic single cycle; request held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        wait_lvl(ack, 1'b1, 64);
        q = rdat[7:0];
        cyc <= 1'b0;
    endtask
    task automatic rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
        input string nm);
        bus(1'b0, a, 8'h00);
        chk(nm, e, q & m);
    endtask
    task automatic no_tick(input int n);
        repeat (n) begin
            @(posedge clk);
            if (tick !== 1'b0) chk("tick while stopped", 8'h00, 8'h01);
        end
    endtask
    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        rdm(8'h18, 8'hFF, 8'h00, "control reset value");
        rdm(8'h2C, 8'hFF, 8'h06, "status reset value");
        rdm(8'hFC, 8'hFF, 8'h00, "unmapped read");
        $display("test reset done");
    endtask
    // try each rate answer, the last one refusing every probe
    task automatic t_estab();
        bus(1'b1, 8'h20, 8'h01);
        for (int r = 3; r >= 0; r--) begin
            okr <= r[1:0];
            bus(1'b1, 8'h18, 8'h20);
            wait_lvl(boost, 1'b1, 4);
            chk("pulse drive and level", 8'h03, {6'h00, loe, lo});
            wait_lvl(irq, 1'b1, 400);
            chk("boost after pulse", 8'h00, {7'h00, boost});
            rdm(8'h18, 8'hFF, {r[1:0], 6'h00}, "control after establish");
            if (r != 0) rdm(8'h30, 8'hFF, 8'h2A, "cycle time");
        end
        $display("test establish done");
    endtask
    task automatic t_wake();
        bus(1'b1, 8'h18, 8'h10);
        wait_lvl(loe, 1'b0, 64);
        chk("wake length", 8'(WAKE + 1), 8'(cnt));
        chk("line echo", 8'h01, {7'h00, lrx});
        rdm(8'h18, 8'hFF, 8'h00, "wake bit cleared");
        $display("test wake done");
    endtask
    // fill the receive queue until it refuses, then clear both queues
    task automatic t_queue();
        for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            rxv <= 1'b1;
            rxb <= 8'(i + 64);
        end
        @(posedge clk);
        rxv <= 1'b0;
        @(posedge clk);
        chk("rx ready when full", 8'h00, {7'h00, rxr});
        rdm(8'h28, 8'hFF, 8'h40, "rx head");
        bus(1'b1, 8'h18, 8'h04);
        rdm(8'h2C, 8'h04, 8'h04, "rx empty after clear");
        bus(1'b1, 8'h24, 8'h55);
        rdm(8'h2C, 8'h02, 8'h00, "tx filled");
        bus(1'b1, 8'h18, 8'h08);
        rdm(8'h2C, 8'h02, 8'h02, "tx empty after clear");
        $display("test queue done");
    endtask
    task automatic t_send();
        stall <= 1'b1;
        bus(1'b1, 8'h24, 8'hA5);
        bus(1'b1, 8'h24, 8'h5A);
        bus(1'b1, 8'h18, 8'h02);
        bus(1'b1, 8'h18, 8'h03);
        rdm(8'h2C, 8'h1A, 8'h18, "sending status");
        chk("tx head", 8'hA5, txb);
        stall <= 1'b0;
        wait_lvl(loe, 1'b0, 200);
        rdm(8'h2C, 8'h12, 8'h02, "status after send");
        rdm(8'h18, 8'hFF, 8'h02, "send bit cleared");
        wait_lvl(tick, 1'b1, 200);
        wait_lvl(tick, 1'b1, 200);
        chk("tick spacing", 8'(CYC), 8'(cnt));
        bus(1'b1, 8'h18, 8'h00);
        no_tick(3 * CYC / 2);
        rdm(8'h2C, 8'h08, 8'h00, "timer stopped");
        bus(1'b1, 8'h18, 8'h02);
        no_tick(3 * CYC / 2);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
        wait_lvl(tick, 1'b1, CYC + 4);
        chk("trigger start", 8'(CYC), 8'(cnt));
        $display("test send done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_estab();
        t_wake();
        t_queue();
        t_send();
        tally_and_finish();
    end
endmodule // lcc_top_tb_top
